//--- common/read_port_pkg.sv
`default_nettype none
package read_port_pkg;

  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0b;
  localparam logic [7:0] OP_FAST_EXT = 8'h0c;
  localparam logic [7:0] OP_DUAL = 8'h3b;
  localparam logic [7:0] OP_DUAL_EXT = 8'h3c;
  localparam logic [7:0] OP_QUAD = 8'h6b;
  localparam logic [7:0] OP_QUAD_EXT = 8'h6c;
  localparam logic [7:0] OP_DUAL_IO = 8'hbb;

  // ==========================================================================
  // Sizes and bit counts
  localparam int BUFFER_BYTES = 2112;
  localparam int COL_W = 12;
  localparam logic [11:0] LAST_COLUMN = 12'h83f;
  localparam logic [5:0] ADDR_BITS = 6'h10;
  localparam logic [5:0] DUMMY_8 = 6'h08;
  localparam logic [5:0] DUMMY_24 = 6'h18;
  localparam logic [5:0] DUMMY_32 = 6'h20;
  localparam logic [5:0] DUMMY_40 = 6'h28;
  localparam logic [2:0] OPCODE_LAST_BIT = 3'h7;
  localparam int SYNC_W = 6;
  // Pin reset levels: chip select idle high, clock and data low
  localparam logic [5:0] PIN_RESET = 6'h20;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {PH_OPCODE, PH_ADDR, PH_DUMMY, PH_DATA, PH_IGNORE} phase_t;

  typedef struct packed {
    logic csN;
    logic sclk;
    logic [3:0] io;
  } pins_t;

  typedef struct packed {
    logic en;
    logic [11:0] addr;
    logic [7:0] data;
  } buf_wr_t;

  typedef struct packed {
    logic valid;
    logic quad;
    logic [2:0] dataLanes;
    logic [2:0] addrLanes;
    logic [5:0] dummyBuf;
    logic [5:0] dummyCont;
  } cmd_t;

  typedef struct packed {
    phase_t phase;
    logic [7:0] opcode;
    logic [5:0] cnt;
    logic [2:0] dataLanes;
    logic [2:0] addrLanes;
    logic [15:0] addr;
    logic [11:0] column;
    logic [7:0] shift;
    logic [2:0] chunk;
    logic [3:0] ioOut;
    logic [3:0] ioOe;
    logic sclkPrev;
    logic nextPage;
  } state_t;

  localparam state_t STATE_RESET = '{
    phase: PH_OPCODE, opcode: 8'h00, cnt: 6'h00, dataLanes: 3'h1, addrLanes: 3'h1,
    addr: 16'h0000, column: 12'h000, shift: 8'h00, chunk: 3'h0, ioOut: 4'h0,
    ioOe: 4'h0, sclkPrev: 1'b0, nextPage: 1'b0};

  function automatic cmd_t decode(input logic [7:0] op);
    cmd_t c;
    c = '{valid: 1'b1, quad: 1'b0, dataLanes: 3'h1, addrLanes: 3'h1,
          dummyBuf: DUMMY_8, dummyCont: DUMMY_32};
    case (op)
      OP_READ: c.dummyCont = DUMMY_24;
      OP_FAST: ;
      OP_FAST_EXT: begin
        c.dummyBuf = DUMMY_24;
        c.dummyCont = DUMMY_40;
      end
      OP_DUAL: c.dataLanes = 3'h2;
      OP_DUAL_EXT: begin
        c.dataLanes = 3'h2;
        c.dummyBuf = DUMMY_24;
        c.dummyCont = DUMMY_40;
      end
      OP_QUAD: begin
        c.dataLanes = 3'h4;
        c.quad = 1'b1;
      end
      OP_QUAD_EXT: begin
        c.dataLanes = 3'h4;
        c.quad = 1'b1;
        c.dummyBuf = DUMMY_24;
        c.dummyCont = DUMMY_40;
      end
      OP_DUAL_IO: begin
        c.dataLanes = 3'h2;
        c.addrLanes = 3'h2;
      end
      default: c.valid = 1'b0;
    endcase
    return c;
  endfunction

endpackage
`default_nettype wire

//--- hw/buffer_read_port.sv
`timescale 1ns/1ps
`default_nettype none
module buffer_read_port (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic csN,
  input wire logic sclk,
  input wire logic [3:0] ioIn,
  output logic [3:0] ioOut,
  output logic [3:0] ioOe,
  input wire logic bufMode,
  input wire logic quadEnable,
  input wire logic wpEnable,
  input wire read_port_pkg::buf_wr_t bufWr,
  output logic nextPage
);
  // ==========================================================================
  // Pin synchronisation and page buffer
  read_port_pkg::pins_t pinsRaw;
  read_port_pkg::pins_t pins;
  read_port_pkg::state_t st_q;
  read_port_pkg::state_t st_d;
  logic [7:0] rdData;

  assign pinsRaw = '{csN: csN, sclk: sclk, io: ioIn};

  pin_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d(pinsRaw),
    .q(pins)
  );

  page_buffer u_buf (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr(bufWr),
    .rdAddr(st_q.column),
    .rdData(rdData)
  );

  // ==========================================================================
  // Lane helpers
  function automatic logic [3:0] gather(input logic [3:0] io, input logic [2:0] w);
    return (w == 3'h2) ? {2'b00, io[1:0]} : {3'b000, io[0]};
  endfunction

  // Top-aligned bits onto pins; single line uses the output pin IO1
  function automatic logic [3:0] lane_map(input logic [3:0] bits, input logic [2:0] w);
    case (w)
      3'h4: return bits;
      3'h2: return {2'b00, bits[3:2]};
      default: return {2'b00, bits[3], 1'b0};
    endcase
  endfunction

  function automatic logic [3:0] lane_oe(input logic [2:0] w);
    case (w)
      3'h4: return 4'hf;
      3'h2: return 4'h3;
      default: return 4'h2;
    endcase
  endfunction

  function automatic logic [2:0] chunks_left(input logic [2:0] w);
    case (w)
      3'h4: return 3'h1;
      3'h2: return 3'h3;
      default: return 3'h7;
    endcase
  endfunction

  // ==========================================================================
  // Sequencer
  logic rise;
  logic fall;
  read_port_pkg::cmd_t cmd;
  logic [7:0] opNext;
  logic [15:0] addrNext;
  logic [3:0] din;

  assign rise = pins.sclk && !st_q.sclkPrev;
  assign fall = !pins.sclk && st_q.sclkPrev;

  always_comb begin
    st_d = st_q;
    st_d.sclkPrev = pins.sclk;
    st_d.nextPage = 1'b0;
    din = gather(pins.io, st_q.addrLanes);
    opNext = {st_q.opcode[6:0], pins.io[0]};
    addrNext = 16'((st_q.addr << st_q.addrLanes) | {12'h000, din});
    cmd = read_port_pkg::decode(opNext);
    if (pins.csN) begin
      // Frame over: drop drive and wait for the next opcode
      st_d.phase = read_port_pkg::PH_OPCODE;
      st_d.cnt = 6'h00;
      st_d.ioOe = 4'h0;
      st_d.chunk = 3'h0;
    end else begin
      case (st_q.phase)
        read_port_pkg::PH_OPCODE: begin
          if (rise) begin
            st_d.opcode = opNext;
            st_d.cnt = 6'(st_q.cnt + 6'h01);
            if (st_q.cnt[2:0] == read_port_pkg::OPCODE_LAST_BIT) begin
              st_d.cnt = read_port_pkg::ADDR_BITS;
              st_d.dataLanes = cmd.dataLanes;
              st_d.addrLanes = cmd.addrLanes;
              if (!cmd.valid) begin
                st_d.phase = read_port_pkg::PH_IGNORE;
              end else if (cmd.quad && (!quadEnable || wpEnable)) begin
                st_d.phase = read_port_pkg::PH_IGNORE;
              end else begin
                st_d.phase = read_port_pkg::PH_ADDR;
              end
            end
          end
        end
        read_port_pkg::PH_ADDR: begin
          if (rise) begin
            st_d.addr = addrNext;
            st_d.cnt = 6'(st_q.cnt - 6'(st_q.addrLanes));
            if (st_q.cnt == 6'(st_q.addrLanes)) begin
              // Continuous mode always starts at byte zero
              st_d.column = bufMode ? addrNext[11:0] : 12'h000;
              cmd = read_port_pkg::decode(st_q.opcode);
              st_d.cnt = bufMode ? cmd.dummyBuf : cmd.dummyCont;
              st_d.phase = read_port_pkg::PH_DUMMY;
            end
          end
        end
        read_port_pkg::PH_DUMMY: begin
          if (rise) begin
            // Dual I/O takes its dummy bits two per clock
            st_d.cnt = 6'(st_q.cnt - 6'(st_q.addrLanes));
            if (st_q.cnt == 6'(st_q.addrLanes)) begin
              st_d.phase = read_port_pkg::PH_DATA;
              st_d.chunk = 3'h0;
            end
          end
        end
        read_port_pkg::PH_DATA: begin
          if (fall) begin
            if (st_q.chunk == 3'h0) begin
              if (bufMode && (st_q.column > read_port_pkg::LAST_COLUMN)) begin
                st_d.ioOe = 4'h0;
              end else begin
                st_d.ioOut = lane_map(rdData[7:4], st_q.dataLanes);
                st_d.ioOe = lane_oe(st_q.dataLanes);
                st_d.shift = 8'(rdData << st_q.dataLanes);
                st_d.chunk = chunks_left(st_q.dataLanes);
                if (!bufMode && (st_q.column == read_port_pkg::LAST_COLUMN)) begin
                  // Loader must refill the buffer before byte zero is due again
                  st_d.column = 12'h000;
                  st_d.nextPage = 1'b1;
                end else begin
                  st_d.column = 12'(st_q.column + 12'h001);
                end
              end
            end else begin
              st_d.ioOut = lane_map(st_q.shift[7:4], st_q.dataLanes);
              st_d.shift = 8'(st_q.shift << st_q.dataLanes);
              st_d.chunk = 3'(st_q.chunk - 3'h1);
            end
          end
        end
        read_port_pkg::PH_IGNORE: begin
          st_d.ioOe = 4'h0;
        end
        default: begin
          st_d.phase = read_port_pkg::PH_IGNORE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= read_port_pkg::STATE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign ioOut = st_q.ioOut;
  assign ioOe = st_q.ioOe;
  assign nextPage = st_q.nextPage;
endmodule // buffer_read_port
`default_nettype wire

//--- hw/page_buffer.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Page buffer: written by the page loader, read one byte at a time
module page_buffer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire read_port_pkg::buf_wr_t wr,
  input wire logic [read_port_pkg::COL_W-1:0] rdAddr,
  output logic [7:0] rdData
);
  logic [7:0] mem [read_port_pkg::BUFFER_BYTES];

  always_ff @(posedge clk_sys) begin
    if (wr.en && (int'(wr.addr) < read_port_pkg::BUFFER_BYTES)) begin
      mem[wr.addr] <= wr.data;
    end
  end

  // Out-of-range columns read as erased; the port never sends them anyway
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdData <= 8'hff;
    end else if (int'(rdAddr) < read_port_pkg::BUFFER_BYTES) begin
      rdData <= mem[rdAddr];
    end else begin
      rdData <= 8'hff;
    end
  end
endmodule // page_buffer
`default_nettype wire

//--- hw/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Two-stage synchroniser for the serial pins
module pin_sync (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [read_port_pkg::SYNC_W-1:0] d,
  output logic [read_port_pkg::SYNC_W-1:0] q
);
  logic [read_port_pkg::SYNC_W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_q <= read_port_pkg::PIN_RESET;
      q <= read_port_pkg::PIN_RESET;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // pin_sync
`default_nettype wire

//--- tb/brp_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Link-side checks on the read port pins
module brp_sva (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic csN,
  input wire logic sclk,
  input wire logic [3:0] ioOut,
  input wire logic [3:0] ioOe,
  input wire logic bufMode,
  input wire logic quadEnable,
  input wire logic wpEnable,
  input wire logic nextPage
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Six cycles covers the two sync stages plus the release latency
  sequence s_csIdle;
    csN [*6];
  endsequence
  sequence s_sclkHigh;
    $rose(sclk) ##1 sclk;
  endsequence
  AST_CS_RELEASE: assert property (s_csIdle |-> ioOe == 4'h0)
    else $error("pins driven while deselected");
  AST_OUT_HOLD: assert property (s_sclkHigh |=> $stable(ioOut) [*3])
    else $error("data moved in clock high phase");
  AST_CHANGE_LOW: assert property ($changed(ioOut) |-> !sclk && !$past(sclk))
    else $error("data moved outside clock low phase");
  AST_OE_START: assert property ($rose(ioOe != 4'h0) |-> !csN && !sclk && !$past(sclk, 2))
    else $error("drive began off a falling edge");
  AST_OE_CODE: assert property (ioOe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("illegal lane enable");
  AST_OE_STEADY: assert property (ioOe != 4'h0 && !csN |=> ioOe == $past(ioOe) || ioOe == 4'h0)
    else $error("lane width changed in frame");
  AST_QUAD_OK: assert property (ioOe == 4'hf |-> quadEnable && !wpEnable)
    else $error("quad read not refused");
  AST_NP_PULSE: assert property (nextPage |=> !nextPage)
    else $error("wrap pulse too long");
  AST_NP_CONT: assert property (nextPage |-> !bufMode && !csN && ioOe != 4'h0)
    else $error("wrap outside continuous read");
endmodule // brp_sva
`default_nettype wire

//--- tb/buffer_read_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin error_cnt++; $display("Error %s exp %h got %h", n, e, s); end end
module buffer_read_port_tb;
  logic clk_sys, rst, csN, sclk, bufMode, quadEnable, wpEnable, nextPage;
  logic [3:0] ioIn, ioOut, ioOe;
  read_port_pkg::buf_wr_t bufWr;
  int error_cnt, total_checks, npCnt;
  buffer_read_port uut (.clk_sys(clk_sys), .rst(rst), .csN(csN), .sclk(sclk), .ioIn(ioIn),
    .ioOut(ioOut), .ioOe(ioOe), .bufMode(bufMode), .quadEnable(quadEnable),
    .wpEnable(wpEnable), .bufWr(bufWr), .nextPage(nextPage));
  host_model host (.clk_sys(clk_sys), .csN(csN), .sclk(sclk), .ioIn(ioIn), .ioOut(ioOut),
    .ioOe(ioOe));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (nextPage === 1'b1) npCnt++;
  function automatic logic [7:0] ex(input int i);
    return 8'(i) ^ 8'(i >> 8);
  endfunction
  task automatic summarize();
    if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ========
  // Rebuild bytes from lane samples, MSB first
  task automatic chk(input int l, input int first, input int n, input logic [3:0] oe);
    logic [7:0] b;
    logic [7:0] s;
    for (int k = 0; k < n; k++) begin
      b = 8'h00;
      for (int j = 0; j < 8 / l; j++) begin
        s = host.smp[k * 8 / l + j];
        b = l == 1 ? {b[6:0], s[1]} : l == 2 ? {b[5:0], s[1:0]} : {b[3:0], s[3:0]};
        `CHK("ioOe", oe, s[7:4])
      end
      `CHK("data", ex((first + k) % 2112), b)
    end
  endtask
  // ========
  // Scenarios
  task automatic t_mode(input logic m);
    logic [7:0] op [3] = '{8'h03, 8'h0b, 8'h0c};
    int db [3] = '{8, 8, 24};
    int dc [3] = '{24, 32, 40};
    bufMode <= m;
    for (int i = 0; i < 3; i++) begin
      host.frame(op[i], 12'h009, m ? db[i] : dc[i], 1, 20);
      chk(1, m ? 9 : 0, 2, 4'h2);
    end
  endtask
  task automatic t_end();
    bufMode <= 1'b1;
    host.frame(8'h0c, 12'h83e, 24, 1, 24);
    chk(1, 2110, 2, 4'h2);
    `CHK("ioOe", 4'h0, host.smp[16][7:4] | host.smp[23][7:4])
    host.frame(8'h0b, 12'h840, 8, 1, 8);
    `CHK("ioOe", 4'h0, host.smp[7][7:4])
  endtask
  task automatic t_wide(input logic m);
    logic [7:0] op [5] = '{8'h3b, 8'h3c, 8'hbb, 8'h6b, 8'h6c};
    int db [5] = '{8, 24, 8, 8, 24};
    int dc [5] = '{32, 40, 32, 32, 40};
    int al [5] = '{1, 1, 2, 1, 1};
    int ln [5] = '{2, 2, 2, 4, 4};
    bufMode <= m;
    quadEnable <= 1'b1;
    wpEnable <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      host.frame(op[i], 12'h007, m ? db[i] : dc[i], al[i], 24 / ln[i]);
      chk(ln[i], m ? 7 : 0, 3, ln[i] == 2 ? 4'h3 : 4'hf);
    end
  endtask
  // Full dummy count, so an accepted quad read would reach its data phase
  task automatic t_refuse();
    bufMode <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      quadEnable <= i[0];
      wpEnable <= i[0];
      host.frame(i[0] ? 8'h6c : 8'h6b, 12'h000, i[0] ? 24 : 8, 1, 4);
      `CHK("ioOe", 4'h0, host.smp[0][7:4] | host.smp[3][7:4])
    end
  endtask
  // Quad keeps the full-page wrap inside the cycle budget
  task automatic t_wrap();
    bufMode <= 1'b0;
    quadEnable <= 1'b1;
    wpEnable <= 1'b0;
    npCnt = 0;
    host.frame(8'h6b, 12'h123, 32, 1, 4228);
    chk(4, 0, 2114, 4'hf);
    `CHK("nextPage", 1, npCnt)
  endtask
  initial begin
    rst = 1'b1;
    bufMode = 1'b1;
    quadEnable = 1'b0;
    wpEnable = 1'b0;
    bufWr = '0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 2112; i++) begin
      @(posedge clk_sys);
      bufWr <= '{en: 1'b1, addr: 12'(i), data: ex(i)};
    end
    @(posedge clk_sys);
    bufWr.en <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_mode(1'b1);
    t_mode(1'b0);
    t_end();
    t_wide(1'b1);
    t_wide(1'b0);
    t_refuse();
    t_wrap();
    summarize();
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    error_cnt++;
    summarize();
  end
endmodule // buffer_read_port_tb
bind buffer_read_port brp_sva chk (.clk_sys(clk_sys), .rst(rst), .csN(csN), .sclk(sclk),
  .ioOut(ioOut), .ioOe(ioOe), .bufMode(bufMode), .quadEnable(quadEnable),
  .wpEnable(wpEnable), .nextPage(nextPage));
`default_nettype wire

//--- tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Host side of the link; clock stands low between frames
module host_model (
  input wire logic clk_sys,
  output logic csN,
  output logic sclk,
  output logic [3:0] ioIn,
  input wire logic [3:0] ioOut,
  input wire logic [3:0] ioOe
);
  logic [7:0] smp [$];
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    ioIn = 4'h0;
  end
  // Sample late in the high phase, well clear of the output change
  task automatic tick(input logic [3:0] d);
    ioIn <= d;
    repeat (4) @(posedge clk_sys);
    sclk <= 1'b1;
    repeat (4) @(posedge clk_sys);
    // A released lane reads as the inverse of the device's last value
    smp.push_back({ioOe, (ioOe & ioOut) | (~ioOe & ~ioOut)});
    sclk <= 1'b0;
  endtask
  task automatic frame(input logic [7:0] op, input logic [11:0] col, input int dum,
                       input int al, input int n);
    logic [15:0] a;
    a = {4'h0, col};
    csN <= 1'b0;
    for (int i = 7; i >= 0; i--) tick({3'h0, op[i]});
    for (int i = 0; i < 16 / al; i++) begin
      tick(al == 2 ? {2'h0, a[15:14]} : {3'h0, a[15]});
      a = a << al;
    end
    repeat (dum / al) tick(4'h0);
    smp.delete();
    // Host toggles ioIn each clock; released lines still read as the inverse of the last value
    repeat (n) tick(~ioIn);
    repeat (4) @(posedge clk_sys);
    csN <= 1'b1;
    ioIn <= ~ioIn;
    repeat (6) @(posedge clk_sys);
  endtask
endmodule // host_model
`default_nettype wire
